// ===== design/idu_top.v
//Function
// - chip type nibble fixed, upper nibble reserved
// - twelve-bit serial split over two registers
// - die revision fixed full byte
// - protocol version fixed byte
// - vendor code low then high byte
// - commit write copies buffered into active
// - commit bit clears itself
// - commit upper seven bits read zero
`timescale 1ns/1ps
`default_nettype none
`include "idu_regs.vh"

module idu_top (
    // clock, reset, enable
    input  wire                      clk,
    input  wire                      arst_n,
    input  wire                      ce,
    // register access from serial port engine
    input  wire [`IDU_ADDR_W-1:0]    regAddr,
    input  wire                      regWrEn,
    input  wire                      regRdEn,
    input  wire [`IDU_DATA_W-1:0]    regWrData,
    output reg  [`IDU_DATA_W-1:0]    regRdData,
    output reg                       regRdValid,
    output reg                       regHit,
    // buffered register image from serial port
    input  wire [`IDU_SHADOW_W-1:0]  shadowBuf,
    // active control registers
    output wire [`IDU_SHADOW_W-1:0]  activeCtrl,
    output reg                       commitDone,
    output reg                       commitPending
);

    // ======================================================================
    // local state
    // ======================================================================
    reg                    commit_reg;
    reg                    commit_next;
    reg                    copyPulse_reg;
    reg [`IDU_DATA_W-1:0]  rdData_next;
    reg                    hit_next;
    wire [`IDU_DATA_W-1:0] idData;
    wire                   idHit;
    wire                   commitSel;
    wire                   commitWrite;

    // ======================================================================
    // identification lookup
    // ======================================================================
    // constant table
    idu_id_rom uRom (
        .addr   (regAddr),
        .idData (idData),
        .idHit  (idHit)
    );

    // ======================================================================
    // commit register
    // ======================================================================
    assign commitSel   = (regAddr == `IDU_OFS_COMMIT);
    assign commitWrite = regWrEn && commitSel && regWrData[`IDU_COMMIT_BIT];

    always @* begin
        commit_next = 1'b0;
        if (commitWrite) begin
            commit_next = 1'b1;
        end
    end

    // request flag, lives exactly one cycle before the copy
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            commit_reg    <= 1'b0;
            copyPulse_reg <= 1'b0;
        end else if (ce) begin
            commit_reg    <= commit_next;
            copyPulse_reg <= commit_reg;
        end
    end

    idu_commit_copy uCopy (
        .clk        (clk),
        .arst_n     (arst_n),
        .ce         (ce),
        .load       (commit_reg),
        .bufData    (shadowBuf),
        .activeData (activeCtrl)
    );

    // ======================================================================
    // read path
    // ======================================================================
    // no write path to identification values
    always @* begin
        rdData_next = `IDU_RDATA_RST;
        hit_next    = idHit | commitSel;
        if (idHit) begin
            rdData_next = idData;
        end else if (commitSel) begin
            rdData_next = {7'h00, commit_reg};
        end
    end

    // registered answer, zero for unmapped offsets
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData     <= `IDU_RDATA_RST;
            regRdValid    <= 1'b0;
            regHit        <= 1'b0;
            commitDone    <= 1'b0;
            commitPending <= 1'b0;
        end else if (ce) begin
            regRdValid    <= regRdEn;
            regHit        <= (regRdEn | regWrEn) & hit_next;
            commitDone    <= commit_reg;
            commitPending <= commit_next;
            if (regRdEn) begin
                regRdData <= rdData_next;
            end
        end
    end

endmodule // idu_top
`default_nettype wire

// ===== include/idu_regs.vh
`ifndef IDU_REGS_VH
`define IDU_REGS_VH

// ==========================================================================
// register offsets on the serial-port register access port
// ==========================================================================
`define IDU_ADDR_W          16
`define IDU_DATA_W          8
`define IDU_OFS_CHIP_TYPE   16'h0003
`define IDU_OFS_SERIAL_LO   16'h0004
`define IDU_OFS_SERIAL_HI   16'h0005
`define IDU_OFS_DIE_REV     16'h0006
`define IDU_OFS_PROTO_VER   16'h000B
`define IDU_OFS_VENDOR_LO   16'h000C
`define IDU_OFS_VENDOR_HI   16'h000D
`define IDU_OFS_COMMIT      16'h000F

// ==========================================================================
// field positions
// ==========================================================================
`define IDU_CHIP_TYPE_MSB   3
`define IDU_SERIAL_LO_MSB   7
`define IDU_SERIAL_LO_LSB   4
`define IDU_COMMIT_BIT      0

// ==========================================================================
// identification values (arbitrary neutral values)
// ==========================================================================
`define IDU_CHIP_TYPE_VAL   4'hA
`define IDU_SERIAL_VAL      12'h3C7
`define IDU_DIE_REV_VAL     8'h21
`define IDU_PROTO_VER_VAL   8'h12
`define IDU_VENDOR_VAL      16'h9B7E
// split views of the multi-register codes, kept in step with the values above
`define IDU_SERIAL_LO_VAL   4'h7
`define IDU_SERIAL_HI_VAL   8'h3C
`define IDU_VENDOR_LO_VAL   8'h7E
`define IDU_VENDOR_HI_VAL   8'h9B

// ==========================================================================
// reset values and sizes
// ==========================================================================
`define IDU_COMMIT_RST      8'h00
`define IDU_RDATA_RST       8'h00
`define IDU_SHADOW_BYTES    16
`define IDU_SHADOW_W        128
`define IDU_COPY_CYCLES     1

`endif

// ===== design/idu_id_rom.v
`timescale 1ns/1ps
`default_nettype none
`include "idu_regs.vh"

// ==========================================================================
// fixed identification read mux
// ==========================================================================
module idu_id_rom (
    // lookup
    input  wire [`IDU_ADDR_W-1:0] addr,
    // result
    output reg  [`IDU_DATA_W-1:0] idData,
    output reg                    idHit
);

    // constant table, no storage so writes cannot alter it
    always @* begin
        idData = `IDU_RDATA_RST;
        idHit  = 1'b1;
        case (addr)
            `IDU_OFS_CHIP_TYPE: idData = {4'h0, `IDU_CHIP_TYPE_VAL};
            `IDU_OFS_SERIAL_LO: idData = {`IDU_SERIAL_LO_VAL, 4'h0};
            `IDU_OFS_SERIAL_HI: idData = `IDU_SERIAL_HI_VAL;
            `IDU_OFS_DIE_REV:   idData = `IDU_DIE_REV_VAL;
            `IDU_OFS_PROTO_VER: idData = `IDU_PROTO_VER_VAL;
            `IDU_OFS_VENDOR_LO: idData = `IDU_VENDOR_LO_VAL;
            `IDU_OFS_VENDOR_HI: idData = `IDU_VENDOR_HI_VAL;
            default:            idHit  = 1'b0;
        endcase
    end

endmodule // idu_id_rom
`default_nettype wire

// ===== design/idu_commit_copy.v
`timescale 1ns/1ps
`default_nettype none
`include "idu_regs.vh"

// ==========================================================================
// buffered to active register copy, one lane per byte
// ==========================================================================
module idu_commit_copy (
    // clock and reset
    input  wire                      clk,
    input  wire                      arst_n,
    input  wire                      ce,
    // control
    input  wire                      load,
    // data
    input  wire [`IDU_SHADOW_W-1:0]  bufData,
    output wire [`IDU_SHADOW_W-1:0]  activeData
);

    genvar i;
    generate
        for (i = 0; i < `IDU_SHADOW_BYTES; i = i + 1) begin : gLane
            // one flop byte per lane, single driver each
            reg [7:0] lane_reg;
            // byte lane takes the buffered value on load
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    lane_reg <= 8'h00;
                end else if (ce && load) begin
                    lane_reg <= bufData[i*8 +: 8];
                end
            end
            assign activeData[i*8 +: 8] = lane_reg;
        end
    endgenerate

endmodule // idu_commit_copy
`default_nettype wire

// ===== sim/idu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// serial port engine stand-in, strobes one cycle each
// ==========================================================================
module idu_host_model (
    input  wire logic        clk,
    output var  logic [15:0] regAddr,
    output var  logic        regWrEn,
    output var  logic        regRdEn,
    output var  logic [7:0]  regWrData,
    input  wire logic [7:0]  regRdData
);
    // idle bus at time zero
    initial begin
        regAddr = 16'h0000;
        regWrEn = 1'h0;
        regRdEn = 1'h0;
        regWrData = 8'h00;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'h1;
        @(posedge clk) #1 regWrEn = 1'h0;
        regAddr = ~a; // released lines show the inverse
        regWrData = ~d;
    endtask
    // read, data one cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        regAddr = a;
        regRdEn = 1'h1;
        @(posedge clk) #1 regRdEn = 1'h0;
        regAddr = ~a;
        @(posedge clk) #1 d = regRdData;
    endtask
endmodule // idu_host_model
`default_nettype wire

// ===== sim/idu_top_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// register bank checker
// ==========================================================================
module idu_props_chk (
    input wire logic         clk, arst_n, ce, regWrEn, regRdEn,
    input wire logic [15:0]  regAddr,
    input wire logic [7:0]   regWrData, regRdData,
    input wire logic         regRdValid, regHit, commitDone, commitPending,
    input wire logic [127:0] shadowBuf, activeCtrl
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // accepted read and commit write
    wire logic rd = ce && regRdEn;
    wire logic cw = ce && regWrEn && regAddr == 16'h000F && regWrData[0];
    sequence sDone; commitPending ##1 commitDone; endsequence
    property pRd(a, v); rd && regAddr == a |=> regHit && regRdValid && regRdData == v; endproperty
    chk_chip_type: assert property (pRd(16'h0003, 8'h0A)) else $error("chip type");
    chk_serial_low: assert property (pRd(16'h0004, 8'h70)) else $error("serial low");
    chk_serial_high: assert property (pRd(16'h0005, 8'h3C)) else $error("serial high");
    chk_die_rev: assert property (pRd(16'h0006, 8'h21)) else $error("die revision");
    chk_proto_ver: assert property (pRd(16'h000B, 8'h12)) else $error("protocol");
    chk_vendor_low: assert property (pRd(16'h000C, 8'h7E)) else $error("vendor low");
    chk_vendor_high: assert property (pRd(16'h000D, 8'h9B)) else $error("vendor high");
    chk_commit_pulse: assert property (cw |=> sDone) else $error("commit pulse");
    chk_commit_copy: assert property (cw ##1 1'h1 |=> activeCtrl == $past(shadowBuf))
        else $error("image copy");
    chk_commit_clear: assert property (commitPending && !cw |=> !commitPending)
        else $error("commit clear");
    chk_commit_rsvd: assert property (rd && regAddr == 16'h000F |=> regRdData[7:1] == 7'h00)
        else $error("commit reserved");
    chk_id_write: assert property (ce && regWrEn && regAddr == 16'h0003 |=> regHit && !regRdValid)
        else $error("id write");
endmodule // idu_props_chk
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// testbench
// ==========================================================================
module tb;
    logic clk = 1'h0, arst_n = 1'h0, ce = 1'h1;
    logic [15:0] regAddr;
    logic regWrEn, regRdEn, regRdValid, regHit, commitDone, commitPending;
    logic [7:0] regWrData, regRdData, d;
    logic [127:0] shadowBuf = 128'h0, activeCtrl;
    int err_total = 0, checks = 0, cyc = 0;
    localparam logic [15:0] ADR [8] = '{16'h0003, 16'h0004, 16'h0005, 16'h0006,
                                        16'h000B, 16'h000C, 16'h000D, 16'h0007};
    localparam logic [7:0] EXP [8] = '{8'h0A, 8'h70, 8'h3C, 8'h21, 8'h12, 8'h7E, 8'h9B, 8'h00};
    always #4 clk = ~clk;
    idu_host_model host (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regWrData(regWrData), .regRdData(regRdData));
    idu_top dut (.clk(clk), .arst_n(arst_n), .ce(ce), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .regHit(regHit), .shadowBuf(shadowBuf),
        .activeCtrl(activeCtrl), .commitDone(commitDone), .commitPending(commitPending));
    task cmp(string n, logic [127:0] e, logic [127:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task give_verdict;
        if (err_total == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // fixed bytes, then writes that must not stick
    task t_ids;
        for (int i = 0; i < 8; i++) begin
            host.rd(ADR[i], d);
            cmp("id read", EXP[i], d);
            host.wr(ADR[i], ~EXP[i]);
            host.rd(ADR[i], d);
            cmp("id after write", EXP[i], d);
        end
    endtask
    // commit copies, self clears, write with commit bit clear refused
    task t_commit;
        cmp("reset image", 128'h0, activeCtrl);
        host.rd(16'h000F, d);
        cmp("commit idle", 8'h00, d);
        shadowBuf = {8{16'hA55A}};
        host.wr(16'h000F, 8'hFF);
        host.rd(16'h000F, d);
        cmp("commit set", 8'h01, d);
        cmp("image", {8{16'hA55A}}, activeCtrl);
        host.rd(16'h000F, d);
        cmp("commit clear", 8'h00, d);
        shadowBuf = ~shadowBuf;
        host.wr(16'h000F, 8'hFE);
        host.rd(16'h000F, d);
        cmp("no copy", {8{16'hA55A}}, activeCtrl);
    endtask
    // enable low freezes commit, then mid-run reset clears the image
    task t_freeze;
        ce = 1'h0;
        shadowBuf = {8{16'h1234}};
        host.wr(16'h000F, 8'h01);
        repeat (2) @(posedge clk);
        #1 cmp("frozen image", {8{16'hA55A}}, activeCtrl);
        ce = 1'h1;
        host.rd(16'h000F, d);
        cmp("frozen commit", 8'h00, d);
        arst_n = 1'h0;
        @(posedge clk) #1 arst_n = 1'h1;
        @(posedge clk) #1;
        cmp("reset again image", 128'h0, activeCtrl);
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            give_verdict;
        end
    end
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        #1 arst_n = 1'h1;
        @(posedge clk) #1;
        t_commit;
        t_freeze;
        t_ids;
        give_verdict;
    end
endmodule // tb
bind idu_top idu_props_chk chk (.clk(clk), .arst_n(arst_n), .ce(ce), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .regHit(regHit), .commitDone(commitDone),
    .commitPending(commitPending), .shadowBuf(shadowBuf), .activeCtrl(activeCtrl));
`default_nettype wire
